// *** hw/prs_readout_sequencer.v ***
// Pixel array readout sequencer with batched register set
`timescale 1ns/1ps
`include "prs_defines.vh"

module prs_readout_sequencer #(
  parameter AW = 16,
  parameter [1:0] BASE_ORDER = 2'h0
) (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rack_o,
  input wire frame_start_i,
  output wire pix_valid_o,
  output wire [AW-1:0] col_addr_o,
  output wire [AW-1:0] row_addr_o,
  output reg line_start_o,
  output reg frame_end_o,
  output wire busy_o,
  output reg [15:0] out_width_o,
  output reg [15:0] out_height_o,
  output reg [15:0] col_count_o,
  output reg [15:0] row_count_o,
  output wire [1:0] pixel_order_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  // ****************************************
  // Staged settings, written by software
  // ****************************************
  reg hold_ff;
  reg [AW-1:0] s_first_col_ff;
  reg [AW-1:0] s_first_row_ff;
  reg [AW-1:0] s_last_col_ff;
  reg [AW-1:0] s_last_row_ff;
  reg [15:0] s_out_w_ff;
  reg [15:0] s_out_h_ff;
  reg [2:0] s_col_inc_ff;
  reg [2:0] s_row_inc_ff;
  reg [1:0] s_orient_ff;
  reg pending_ff;

  // ****************************************
  // Active settings, used by the sequencer
  // ****************************************
  reg [AW-1:0] a_first_col_ff;
  reg [AW-1:0] a_first_row_ff;
  reg [AW-1:0] a_last_col_ff;
  reg [AW-1:0] a_last_row_ff;
  reg [2:0] a_col_inc_ff;
  reg [2:0] a_row_inc_ff;
  reg [1:0] a_orient_ff;

  reg state_ff;
  reg nxt_state;
  wire apply;
  wire col_end;
  wire row_end;
  reg col_load;
  reg col_step;
  reg row_load;
  reg row_step;
  wire wr_any;
  wire [15:0] col_span;
  wire [15:0] row_span;

  // Illegal increments fall back to no subsampling
  function [2:0] legal_inc;
    input [15:0] v;
    begin
      case (v[2:0])
        `PRS_INC_3: legal_inc = `PRS_INC_3;
        `PRS_INC_7: legal_inc = `PRS_INC_7;
        default: legal_inc = `PRS_INC_1;
      endcase
    end
  endfunction

  // Divide span by (inc+1)/2 as a shift
  function [15:0] skip_div;
    input [15:0] span;
    input [2:0] inc;
    begin
      case (inc)
        `PRS_INC_3: skip_div = {1'b0, span[15:1]};
        `PRS_INC_7: skip_div = {2'b00, span[15:2]};
        default: skip_div = span;
      endcase
    end
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  // Orientation is staged too, so only the hold write is left out
  assign wr_any = reg_wr_i && (reg_addr_i != `PRS_ADDR_HOLD);

  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff <= 1'b0;
      s_first_col_ff <= `PRS_RST_FIRST_COL;
      s_first_row_ff <= `PRS_RST_FIRST_ROW;
      s_last_col_ff <= `PRS_RST_LAST_COL;
      s_last_row_ff <= `PRS_RST_LAST_ROW;
      s_out_w_ff <= `PRS_RST_OUT_W;
      s_out_h_ff <= `PRS_RST_OUT_H;
      s_col_inc_ff <= `PRS_RST_INC;
      s_row_inc_ff <= `PRS_RST_INC;
      s_orient_ff <= 2'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PRS_ADDR_HOLD: hold_ff <= reg_wdata_i[`PRS_BIT_HOLD];
        `PRS_ADDR_FIRST_COL: s_first_col_ff <= reg_wdata_i[AW-1:0];
        `PRS_ADDR_FIRST_ROW: s_first_row_ff <= reg_wdata_i[AW-1:0];
        `PRS_ADDR_LAST_COL: s_last_col_ff <= reg_wdata_i[AW-1:0];
        `PRS_ADDR_LAST_ROW: s_last_row_ff <= reg_wdata_i[AW-1:0];
        `PRS_ADDR_OUT_W: s_out_w_ff <= reg_wdata_i;
        `PRS_ADDR_OUT_H: s_out_h_ff <= reg_wdata_i;
        `PRS_ADDR_COL_INC: s_col_inc_ff <= legal_inc(reg_wdata_i); // R4
        `PRS_ADDR_ROW_INC: s_row_inc_ff <= legal_inc(reg_wdata_i); // R4
        `PRS_ADDR_ORIENT: s_orient_ff <= {reg_wdata_i[`PRS_BIT_FLIP], reg_wdata_i[`PRS_BIT_MIRROR]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // Frame boundary transfer
  // ****************************************
  // Only between frames and with the hold released
  assign apply = frame_start_i && (state_ff == ST_IDLE) && !hold_ff; // R15

  // Set wins over clear: a write in the apply cycle stays pending
  always @(posedge clk_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
    end else if (wr_any) begin
      pending_ff <= 1'b1;
    end else if (apply) begin
      pending_ff <= 1'b0; // R15
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      a_first_col_ff <= `PRS_RST_FIRST_COL;
      a_first_row_ff <= `PRS_RST_FIRST_ROW;
      a_last_col_ff <= `PRS_RST_LAST_COL;
      a_last_row_ff <= `PRS_RST_LAST_ROW;
      a_col_inc_ff <= `PRS_RST_INC;
      a_row_inc_ff <= `PRS_RST_INC;
      a_orient_ff <= 2'h0;
      out_width_o <= `PRS_RST_OUT_W;
      out_height_o <= `PRS_RST_OUT_H;
    end else if (apply) begin
      a_first_col_ff <= s_first_col_ff; // R15
      a_first_row_ff <= s_first_row_ff;
      a_last_col_ff <= s_last_col_ff;
      a_last_row_ff <= s_last_row_ff;
      a_col_inc_ff <= s_col_inc_ff; // R12
      a_row_inc_ff <= s_row_inc_ff; // R12
      a_orient_ff <= s_orient_ff;
      out_width_o <= s_out_w_ff; // R14
      out_height_o <= s_out_h_ff; // R14
    end
  end

  // ****************************************
  // Derived output counts
  // ****************************************
  assign col_span = {{(16-AW){1'b0}}, a_last_col_ff - a_first_col_ff} + {13'h0000, a_col_inc_ff};
  assign row_span = {{(16-AW){1'b0}}, a_last_row_ff - a_first_row_ff} + {13'h0000, a_row_inc_ff};

  always @(posedge clk_i) begin
    if (rst_i) begin
      col_count_o <= 16'h0000;
      row_count_o <= 16'h0000;
    end else begin
      col_count_o <= skip_div(col_span, a_col_inc_ff); // R7 R5 R6
      row_count_o <= skip_div(row_span, a_row_inc_ff); // R7 R5 R6
    end
  end

  // Mirror swaps colour within a row, flip swaps row colours
  assign pixel_order_o = BASE_ORDER ^ a_orient_ff; // R2

  // ****************************************
  // Frame sequencing
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    col_load = 1'b0;
    col_step = 1'b0;
    row_load = 1'b0;
    row_step = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (frame_start_i) begin
          nxt_state = ST_RUN;
          col_load = 1'b1;
          row_load = 1'b1;
        end
      end
      ST_RUN: begin
        if (!col_end) begin
          col_step = 1'b1; // R1 R9
        end else if (!row_end) begin
          col_load = 1'b1;
          row_step = 1'b1; // R3 R9
        end else begin
          nxt_state = ST_IDLE; // R13
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      line_start_o <= 1'b0;
      frame_end_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      line_start_o <= col_load;
      frame_end_o <= (state_ff == ST_RUN) && (nxt_state == ST_IDLE);
    end
  end

  assign pix_valid_o = (state_ff == ST_RUN);
  assign busy_o = (state_ff == ST_RUN);

  // Axes load from staged values when this start also applies them
  prs_axis_seq #(
    .AW(AW)
  ) u_col (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(col_load),
    .step_i(col_step),
    .first_i(apply ? s_first_col_ff : a_first_col_ff),
    .last_i(apply ? s_last_col_ff : a_last_col_ff),
    .inc_i(apply ? s_col_inc_ff : a_col_inc_ff),
    .rev_i(apply ? s_orient_ff[`PRS_BIT_MIRROR] : a_orient_ff[`PRS_BIT_MIRROR]),
    .addr_o(col_addr_o),
    .end_o(col_end)
  );

  prs_axis_seq #(
    .AW(AW)
  ) u_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(row_load),
    .step_i(row_step),
    .first_i(apply ? s_first_row_ff : a_first_row_ff),
    .last_i(apply ? s_last_row_ff : a_last_row_ff),
    .inc_i(apply ? s_row_inc_ff : a_row_inc_ff),
    .rev_i(apply ? s_orient_ff[`PRS_BIT_FLIP] : a_orient_ff[`PRS_BIT_FLIP]),
    .addr_o(row_addr_o),
    .end_o(row_end)
  );

  // ****************************************
  // Register reads
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rack_o <= 1'b0;
    end else begin
      reg_rack_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `PRS_ADDR_HOLD: reg_rdata_o <= {15'h0000, hold_ff};
          `PRS_ADDR_FIRST_COL: reg_rdata_o <= {{(16-AW){1'b0}}, s_first_col_ff};
          `PRS_ADDR_FIRST_ROW: reg_rdata_o <= {{(16-AW){1'b0}}, s_first_row_ff};
          `PRS_ADDR_LAST_COL: reg_rdata_o <= {{(16-AW){1'b0}}, s_last_col_ff};
          `PRS_ADDR_LAST_ROW: reg_rdata_o <= {{(16-AW){1'b0}}, s_last_row_ff};
          `PRS_ADDR_OUT_W: reg_rdata_o <= s_out_w_ff;
          `PRS_ADDR_OUT_H: reg_rdata_o <= s_out_h_ff;
          `PRS_ADDR_COL_INC: reg_rdata_o <= {13'h0000, s_col_inc_ff};
          `PRS_ADDR_ROW_INC: reg_rdata_o <= {13'h0000, s_row_inc_ff};
          `PRS_ADDR_ORIENT: reg_rdata_o <= {14'h0000, s_orient_ff};
          `PRS_ADDR_PIX_ORDER: reg_rdata_o <= {14'h0000, pixel_order_o}; // R2
          `PRS_ADDR_STATUS: reg_rdata_o <= {14'h0000, pending_ff, busy_o};
          `PRS_ADDR_COL_CNT: reg_rdata_o <= col_count_o;
          `PRS_ADDR_ROW_CNT: reg_rdata_o <= row_count_o;
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// *** inc/prs_defines.vh ***
// Constants for the pixel array readout sequencer
// Summary of operation
// R1 - Column reverse reads last column down to first
// R2 - Column reverse flips reported Bayer pixel order
// R3 - Row reverse reads last row down to first
// R4 - Per-axis increment accepts 1, 3 or 7
// R5 - Increment 3 both axes gives quarter image
// R6 - Increment 7 both axes gives sixteenth image
// R7 - Count is (end-start+inc) over (inc+1)/2
// R8 - Host aligns addresses to skip sequence multiples
// R9 - Read address pairs, skip two or six
// R10 - Start alignment picks the subsampling phase
// R11 - Host keeps line period across mode switches
// R12 - Each axis subsampled by own increment only
// R13 - Sequence only inside programmed window
// R14 - Output size from output width/height registers
// R15 - Batch hold defers settings to frame boundary
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define PRS_ADDR_HOLD 16'h0104
`define PRS_ADDR_FIRST_COL 16'h0344
`define PRS_ADDR_FIRST_ROW 16'h0346
`define PRS_ADDR_LAST_COL 16'h0348
`define PRS_ADDR_LAST_ROW 16'h034A
`define PRS_ADDR_OUT_W 16'h034C
`define PRS_ADDR_OUT_H 16'h034E
`define PRS_ADDR_COL_INC 16'h0382
`define PRS_ADDR_ROW_INC 16'h0386
`define PRS_ADDR_ORIENT 16'h0500
`define PRS_ADDR_PIX_ORDER 16'h0502
`define PRS_ADDR_STATUS 16'h0504
`define PRS_ADDR_COL_CNT 16'h0506
`define PRS_ADDR_ROW_CNT 16'h0508

// ****************************************
// Fields
// ****************************************
`define PRS_BIT_HOLD 0
`define PRS_BIT_MIRROR 0
`define PRS_BIT_FLIP 1
`define PRS_BIT_BUSY 0
`define PRS_BIT_PENDING 1

// ****************************************
// Reset values
// ****************************************
`define PRS_RST_FIRST_COL 16'h0008
`define PRS_RST_FIRST_ROW 16'h0008
`define PRS_RST_LAST_COL 16'h0A27
`define PRS_RST_LAST_ROW 16'h079F
`define PRS_RST_OUT_W 16'h0A20
`define PRS_RST_OUT_H 16'h0798
`define PRS_RST_INC 3'h1

// ****************************************
// Increment codes
// ****************************************
`define PRS_INC_1 3'h1
`define PRS_INC_3 3'h3
`define PRS_INC_7 3'h7

`endif

// *** hw/prs_axis_seq.v ***
// One axis address sequencer: pairs, skips, direction
`timescale 1ns/1ps
`include "prs_defines.vh"

module prs_axis_seq #(
  parameter AW = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire step_i,
  input wire [AW-1:0] first_i,
  input wire [AW-1:0] last_i,
  input wire [2:0] inc_i,
  input wire rev_i,
  output wire [AW-1:0] addr_o,
  output wire end_o
);

  reg [AW-1:0] addr_ff;
  reg pair_ff;
  reg [AW-1:0] nxt_addr;
  reg nxt_pair;
  wire [AW-1:0] jump;

  // Second of a pair jumps by the increment, first moves by one
  assign jump = pair_ff ? {{(AW-3){1'b0}}, inc_i} : {{(AW-1){1'b0}}, 1'b1}; // R9 R12
  assign addr_o = addr_ff;
  // Terminal address depends on direction
  assign end_o = (addr_ff == (rev_i ? first_i : last_i)); // R1 R3 R13

  always @* begin
    nxt_addr = addr_ff;
    nxt_pair = pair_ff;
    if (load_i) begin
      nxt_addr = rev_i ? last_i : first_i; // R1 R3 R10
      nxt_pair = 1'b0;
    end else if (step_i) begin
      nxt_addr = rev_i ? (addr_ff - jump) : (addr_ff + jump); // R9
      nxt_pair = ~pair_ff;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= {AW{1'b0}};
      pair_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      pair_ff <= nxt_pair;
    end
  end

endmodule

// *** tb/prs_readout_checker.sv ***
// Port assertions for the readout sequencer
`timescale 1ns/1ps
module prs_readout_checker #(
  parameter AW = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire reg_rd_i,
  input wire reg_rack_o,
  input wire frame_start_i,
  input wire pix_valid_o,
  input wire [AW-1:0] col_addr_o,
  input wire [AW-1:0] row_addr_o,
  input wire line_start_o,
  input wire frame_end_o,
  input wire busy_o,
  input wire [15:0] out_width_o,
  input wire [15:0] col_count_o,
  input wire [1:0] pixel_order_o
);
  reg [AW-1:0] prev_col_ff;
  reg start_ok_ff;
  wire [AW-1:0] dcol = (col_addr_o > prev_col_ff) ? col_addr_o - prev_col_ff : prev_col_ff - col_addr_o;
  always @(posedge clk_i) begin
    prev_col_ff <= col_addr_o;
    start_ok_ff <= frame_start_i && !busy_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_start_to_valid: assert property (frame_start_i && !busy_o |=> pix_valid_o && line_start_o)
    else $error("no pixels after start");
  a_col_step: assert property (pix_valid_o && !line_start_o |-> dcol inside {1, 3, 7})
    else $error("bad column step");
  a_row_hold: assert property (pix_valid_o && !line_start_o |-> $stable(row_addr_o))
    else $error("row moved inside line");
  a_new_row: assert property (line_start_o && $past(pix_valid_o) |-> row_addr_o != $past(row_addr_o))
    else $error("row not advanced");
  a_frame_end: assert property ($fell(pix_valid_o) |-> frame_end_o)
    else $error("frame end missing");
  a_order_apply: assert property ($changed(pixel_order_o) |-> start_ok_ff)
    else $error("pixel order moved off boundary");
  a_width_apply: assert property ($changed(out_width_o) |-> start_ok_ff)
    else $error("width moved off boundary");
  a_count_lag: assert property ($changed(col_count_o) |-> $past(start_ok_ff) || $past(rst_i, 2))
    else $error("count moved off boundary");
  a_read_ack: assert property (reg_rack_o == $past(reg_rd_i))
    else $error("read ack timing");
endmodule

bind prs_readout_sequencer prs_readout_checker #(.AW(AW)) i_chk (.clk_i, .rst_i, .reg_rd_i, .reg_rack_o,
  .frame_start_i, .pix_valid_o, .col_addr_o, .row_addr_o, .line_start_o, .frame_end_o, .busy_o,
  .out_width_o, .col_count_o, .pixel_order_o);

// *** tb/prs_readout_sequencer_tb.sv ***
// Self-checking testbench for the readout sequencer
`timescale 1ns/1ps
module prs_readout_sequencer_tb;
  reg clk_i = 0;
  reg rst_i = 1;
  reg [15:0] reg_addr_i = 16'h0000;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 0;
  reg reg_rd_i = 0;
  reg frame_start_i = 0;
  wire [15:0] reg_rdata_o, col_addr_o, row_addr_o, out_width_o, out_height_o, col_count_o, row_count_o;
  wire reg_rack_o, pix_valid_o, line_start_o, frame_end_o, busy_o;
  wire [1:0] pixel_order_o;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  logic [15:0] cq[$];
  logic [15:0] rq[$];

  prs_readout_sequencer i_dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .reg_rack_o, .frame_start_i, .pix_valid_o, .col_addr_o, .row_addr_o, .line_start_o,
    .frame_end_o, .busy_o, .out_width_o, .out_height_o, .col_count_o, .row_count_o, .pixel_order_o);

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      results;
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task wr(input [15:0] a, input [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask

  task rd(input [15:0] a, input [15:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1;
    check(reg_rack_o, 1);
    check(reg_rdata_o, exp);
  endtask

  // Expected axis order: pairs, then a jump of inc
  task gen(input [15:0] f, input [15:0] l, input [15:0] inc, input rev, input is_row);
    logic [15:0] a;
    integer k;
    if (is_row) rq.delete();
    else cq.delete();
    a = rev ? l : f;
    for (k = 0; k < 64; k++) begin
      if (is_row) rq.push_back(a);
      else cq.push_back(a);
      if (a == (rev ? f : l)) break;
      a = rev ? a - ((k % 2) ? inc : 1) : a + ((k % 2) ? inc : 1);
    end
  endtask

  task win(input [15:0] c0, c1, ci, r0, r1, ri, input [1:0] o);
    wr(16'h0344, c0);
    wr(16'h0348, c1);
    wr(16'h0382, ci);
    wr(16'h0346, r0);
    wr(16'h034A, r1);
    wr(16'h0386, ri);
    wr(16'h0500, {14'h0000, o});
  endtask

  task frame(input [15:0] c0, c1, ci, r0, r1, ri, input [1:0] o);
    gen(c0, c1, ci, o[0], 1'b0);
    gen(r0, r1, ri, o[1], 1'b1);
    @(posedge clk_i);
    frame_start_i <= 1;
    @(posedge clk_i);
    frame_start_i <= 0;
    #1;
    foreach (rq[i]) foreach (cq[j]) begin
      check(pix_valid_o, 1);
      check(busy_o, 1);
      check(line_start_o, j == 0);
      check(col_addr_o, cq[j]);
      check(row_addr_o, rq[i]);
      @(posedge clk_i);
      #1;
    end
    check(pix_valid_o, 0);
    check(busy_o, 0);
    check(frame_end_o, 1);
    check(pixel_order_o, o);
  endtask

  task t_reset;
    rd(16'h0344, 16'h0008);
    rd(16'h034A, 16'h079F);
    rd(16'h0382, 16'h0001);
    rd(16'h034C, 16'h0A20);
    rd(16'h0200, 16'h0000);
    check(out_width_o, 16'h0A20);
    check(out_height_o, 16'h0798);
    check(col_count_o, 16'h0A20);
    check(row_count_o, 16'h0798);
    $display("reset test done");
  endtask

  task t_skip2;
    win(0, 5, 3, 0, 5, 3, 0);
    frame(0, 5, 3, 0, 5, 3, 0);
    rd(16'h0506, 16'h0004);
    rd(16'h0508, 16'h0004);
    win(8, 13, 3, 2, 7, 3, 0);
    frame(8, 13, 3, 2, 7, 3, 0);
    rd(16'h0508, 16'h0004);
    $display("skip2 test done");
  endtask

  task t_reverse;
    win(0, 9, 7, 0, 9, 7, 3);
    frame(0, 9, 7, 0, 9, 7, 3);
    rd(16'h0502, 16'h0003);
    rd(16'h0506, 16'h0004);
    rd(16'h0508, 16'h0004);
    $display("reverse test done");
  endtask

  task t_hold;
    wr(16'h0104, 1);
    win(0, 1, 1, 0, 1, 1, 0);
    wr(16'h034C, 16'h0010);
    frame(0, 9, 7, 0, 9, 7, 3);
    check(out_width_o, 16'h0A20);
    rd(16'h0504, 16'h0002);
    wr(16'h0104, 0);
    frame(0, 1, 1, 0, 1, 1, 0);
    check(out_width_o, 16'h0010);
    rd(16'h0504, 16'h0000);
    $display("hold test done");
  endtask

  task t_inc;
    win(0, 3, 5, 0, 9, 7, 0);
    rd(16'h0382, 16'h0001);
    rd(16'h0386, 16'h0007);
    frame(0, 3, 1, 0, 9, 7, 0);
    check(col_count_o, 16'h0004);
    check(row_count_o, 16'h0004);
    $display("increment test done");
  endtask

  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_skip2;
    t_reverse;
    t_hold;
    t_inc;
    results;
  end
endmodule
